/* bench/cdr_periph_model.sv */
// bench model of the console peripherals: printer, punch, teletype port and tape reader
`timescale 1ns/1ps
`default_nettype none
module cdr_periph_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	// requests from the block, bit 0 printer, 1 punch, 2 teletype port
	input  wire logic [2:0] strobe_i,
	input  wire logic       advance_i,
	// answers to the block
	output logic [2:0]      done_o,
	output logic            rdr_ready_o,
	output logic            rdr_feed_hole_o,
	output logic [7:0]      rdr_data_o
);
	logic [7:0] tape[$];
	int         cnt[3];
	int         mv;

	// the bench threads frames onto the reader
	task load(input logic [7:0] f);
		tape.push_back(f);
	endtask : load

	// each device reports done one to four cycles after its strobe, so slow and prompt both occur
	always @(posedge clk_i)
	begin
		for (int i = 0; i < 3; i++)
		begin
			done_o[i] <= 1'b0;
			if (sys_rst_i)
				cnt[i] = 0;
			else if (strobe_i[i])
				cnt[i] = 1 + $urandom % 4;
			else if (cnt[i] > 0)
			begin
				cnt[i]--;
				done_o[i] <= (cnt[i] == 0);
			end
		end
	end

	// moving tape hides the frame for three cycles; the data lines then toggle, never hold
	always @(posedge clk_i)
	begin
		if (sys_rst_i || advance_i)
		begin
			if (advance_i && tape.size() > 0)
				void'(tape.pop_front());
			mv = 3;
			rdr_ready_o <= 1'b0;
			rdr_feed_hole_o <= 1'b0;
		end
		else if (mv > 0)
			mv--;
		else
		begin
			rdr_ready_o <= 1'b1;
			rdr_feed_hole_o <= (tape.size() > 0);
		end
		if (sys_rst_i)
			rdr_data_o <= 8'h5A;
		else
			rdr_data_o <= (mv == 0 && tape.size() > 0) ? tape[0] : ~rdr_data_o;
	end
endmodule : cdr_periph_model
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the console data routing control
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_i = 0, sys_rst_i = 1, online_sel_i = 0, reader_enable_i = 0, periph_offline_i = 0;
	logic [2:0] route_sel_i = 3'h0;
	logic [1:0] level_sel_i = 2'h3;
	logic host_func_valid_i = 0, host_data_valid_i = 0, host_in_ack_i = 0, kbd_valid_i = 0;
	logic host_intr_i = 0;
	logic [3:0] host_func_i = 4'h0;
	logic [7:0] host_data_i = 8'h00, host_in_data_o, rdr_data_i, pun_data_o, v, m;
	logic [6:0] kbd_data_i = 7'h00, prt_data_o, teletype_output_port_data_o;
	logic host_func_ready_o, host_data_ready_o, host_in_valid_o, console_intr_o, kbd_ready_o;
	logic rdr_ready_i, rdr_feed_hole_i, rdr_advance_o, prt_strobe_o, pun_strobe_o;
	logic teletype_output_port_strobe_o, online_o, busy_o;
	logic [2:0] done;
	logic [7:0] q_prt[$], q_pun[$], q_host[$], q_tele[$];
	int n_errors = 0, n_checks = 0, outst = 0, n_intr = 0, exp_intr = 0, n_prt = 0, n_pun = 0;
	int hold = 0;

	cdr_route_ctrl DUT (.clk_i, .sys_rst_i, .online_sel_i, .route_sel_i, .reader_enable_i,
		.level_sel_i, .periph_offline_i, .host_func_valid_i, .host_func_i, .host_func_ready_o,
		.host_data_valid_i, .host_data_i, .host_data_ready_o, .host_in_valid_o, .host_in_data_o,
		.host_in_ack_i, .host_intr_i, .console_intr_o, .kbd_valid_i, .kbd_data_i,
		.kbd_ready_o, .rdr_ready_i, .rdr_feed_hole_i, .rdr_data_i, .rdr_advance_o,
		.prt_strobe_o, .prt_data_o, .prt_done_i(done[0]), .pun_strobe_o, .pun_data_o,
		.pun_done_i(done[1]), .teletype_output_port_strobe_o, .teletype_output_port_data_o,
		.teletype_output_port_done_i(done[2]), .online_o, .busy_o);

	cdr_periph_model u_periph (.clk_i, .sys_rst_i,
		.strobe_i({teletype_output_port_strobe_o, pun_strobe_o, prt_strobe_o}),
		.advance_i(rdr_advance_o), .done_o(done), .rdr_ready_o(rdr_ready_i),
		.rdr_feed_hole_o(rdr_feed_hole_i), .rdr_data_o(rdr_data_i));

	// 250 MHz clock
	initial
	begin
		forever #2 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// an empty queue expects x, so any unexpected delivery is a mismatch
	task automatic pop_chk(input string nm, ref logic [7:0] q[$], input logic [7:0] g);
		chk(nm, (q.size() > 0) ? q.pop_front() : 8'bx, g);
	endtask : pop_chk

	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	// hold one request (0 function, 1 host word, 2 key) until the edge that takes it
	task automatic send(input int k, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge clk_i);
		host_func_valid_i = (k == 0);
		host_func_i = d[3:0];
		host_data_valid_i = (k == 1);
		host_data_i = d;
		kbd_valid_i = (k == 2);
		kbd_data_i = d[6:0];
		while ((k == 0 ? host_func_ready_o : k == 1 ? host_data_ready_o : kbd_ready_o) !== 1'b1
			&& n < 400)
		begin
			@(negedge clk_i);
			n++;
		end
		chk("request taken", 8'h1, 8'(n < 400));
		@(negedge clk_i);
		host_func_valid_i = 0;
		host_data_valid_i = 0;
		kbd_valid_i = 0;
	endtask : send

	// wait until the sequencer has gone idle, bounded
	task automatic settle();
		int n;
		n = 0;
		repeat (4) @(negedge clk_i);
		while (busy_o !== 1'b0 && n < 3000)
		begin
			@(negedge clk_i);
			n++;
		end
		chk("sequencer idle", 8'h0, {7'h00, busy_o});
	endtask : settle

	// result monitor: every delivery is compared with the bench model's queues
	always @(negedge clk_i)
	begin
		if (prt_strobe_o)
		begin
			pop_chk("printer", q_prt, {1'b0, prt_data_o});
			if (route_sel_i == 3'h4 && !online_o)
				chk("punch before print", 8'h1, 8'(n_pun > n_prt));
			n_prt++;
		end
		if (pun_strobe_o)
		begin
			pop_chk("punch", q_pun, pun_data_o);
			n_pun++;
		end
		if (teletype_output_port_strobe_o)
			pop_chk("teletype port", q_tele, {1'b0, teletype_output_port_data_o});
		outst += int'(prt_strobe_o) + int'(pun_strobe_o) + int'(teletype_output_port_strobe_o);
		outst -= int'(done[0]) + int'(done[1]) + int'(done[2]);
		if (rdr_advance_o)
			chk("actions open at advance", 8'h0, 8'(outst));
		if (console_intr_o)
			n_intr++;
		// ack pulses one cycle, then the monitor ignores host_in_valid_o for three more cycles
		if (hold > 0)
		begin
			hold--;
			host_in_ack_i = 0;
		end
		else if (host_in_valid_o)
		begin
			pop_chk("host word", q_host, host_in_data_o);
			host_in_ack_i = 1;
			hold = 3;
		end
	end

	// watchdog: the tests need a few hundred cycles
	initial
	begin
		#80000;
		n_errors++;
		final_report();
	end

	initial
	begin
		void'($urandom(83));
		repeat (16) @(negedge clk_i);
		sys_rst_i = 0;
		// off-line keyboard routes
		for (int r = 0; r < 2; r++)
		begin
			route_sel_i = 3'(r);
			repeat (3)
			begin
				v = 8'($urandom % 128);
				q_prt.push_back(v);
				if (r == 1)
					q_pun.push_back(v);
				send(2, v);
			end
			settle();
		end
		// off-line reader routes with a random tape level
		for (int r = 2; r < 5; r++)
		begin
			route_sel_i = 3'(r);
			// counts restart per route so earlier keyboard prints do not skew the order check
			n_prt = 0;
			n_pun = 0;
			level_sel_i = 2'($urandom % 4);
			repeat (3)
			begin
				v = 8'($urandom);
				u_periph.load(v);
				m = v & (8'hFF >> (2'h3 - level_sel_i));
				if (r != 3)
					q_pun.push_back(m);
				if (r != 2)
					q_prt.push_back({1'b0, m[6:0]});
			end
			reader_enable_i = 1;
			if (r == 4)
			begin
				repeat (6) @(negedge clk_i);
				online_sel_i = 1;
				repeat (3) @(negedge clk_i);
				chk("mode held mid frame", 8'h0, {7'h00, online_o});
			end
			settle();
			reader_enable_i = 0;
		end
		repeat (3) @(negedge clk_i);
		chk("on-line latched", 8'h1, {7'h00, online_o});
		// on-line: keys to computer and printer, host words to printer and punch together
		send(0, 8'h01);
		send(0, 8'h06);
		repeat (2)
		begin
			v = 8'($urandom % 128);
			q_prt.push_back(v);
			q_host.push_back(v);
			exp_intr++;
			send(2, v);
		end
		repeat (2)
		begin
			v = 8'($urandom);
			q_prt.push_back({1'b0, v[6:0]});
			q_pun.push_back(v);
			send(1, v);
		end
		// punch-only output function
		send(0, 8'h05);
		v = 8'($urandom);
		q_pun.push_back(v);
		send(1, v);
		settle();
		// on-line reader input: frames to the computer, end of tape interrupts
		level_sel_i = 2'h3;
		repeat (2)
		begin
			v = 8'($urandom);
			u_periph.load(v);
			q_host.push_back(v);
			exp_intr++;
		end
		exp_intr++;
		send(0, 8'h02);
		settle();
		// peripherals off-line: printer refused, teletype port served
		send(0, 8'h08);
		periph_offline_i = 1;
		send(0, 8'h04);
		repeat (2) @(negedge clk_i);
		chk("printer gated", 8'h0, {7'h00, host_data_ready_o});
		send(0, 8'h07);
		v = 8'($urandom);
		q_tele.push_back({1'b0, v[6:0]});
		send(1, v);
		settle();
		// input stop drops only the key path; a computer interrupt then clears the output too
		send(0, 8'h01);
		send(0, 8'h03);
		chk("input stopped", 8'h2, {6'h00, host_data_ready_o, kbd_ready_o});
		host_intr_i = 1;
		@(negedge clk_i);
		host_intr_i = 0;
		chk("functions cleared", 8'h0, {6'h00, host_data_ready_o, kbd_ready_o});
		repeat (8) @(negedge clk_i);
		chk("undelivered words", 8'h0, 8'(q_prt.size() + q_pun.size() + q_host.size()));
		chk("interrupt pulses", 8'(exp_intr), 8'(n_intr));
		final_report();
	end
endmodule : tb
`default_nettype wire

/* design/cdr_pkg.sv */
// shared constants and types for the console data routing control
package cdr_pkg;

	// frame and character widths
	localparam int FRAME_W = 8;
	localparam int KEY_W   = 7;

	// destination mask bit positions
	localparam int DEST_W = 4;
	localparam int D_PUN  = 0;
	localparam int D_PRT  = 1;
	localparam int D_HOST = 2;
	localparam int D_TTY  = 3;
	localparam logic [3:0] DEST_NONE = 4'h0;
	localparam logic [3:0] DEST_PUN  = 4'h1;
	localparam logic [3:0] DEST_PRT  = 4'h2;
	localparam logic [3:0] DEST_HOST = 4'h4;
	localparam logic [3:0] DEST_TTY  = 4'h8;

	// full eight-level frame mask, narrowed by the level select
	localparam logic [7:0] FRAME_ALL = 8'hFF;
	localparam logic [1:0] LEVEL_TOP = 2'h3;

	// off-line panel routes
	typedef enum logic [2:0] {
		CDR_RT_KBD_PRT     = 3'h0,
		CDR_RT_KBD_PRT_PUN = 3'h1,
		CDR_RT_RDR_PUN     = 3'h2,
		CDR_RT_RDR_PRT     = 3'h3,
		CDR_RT_RDR_PRT_PUN = 3'h4
	} cdr_route_e;

	// external function words from the computer
	typedef enum logic [3:0] {
		CDR_FN_NOP      = 4'h0,
		CDR_FN_IN_KBD   = 4'h1,
		CDR_FN_IN_RDR   = 4'h2,
		CDR_FN_IN_STOP  = 4'h3,
		CDR_FN_OUT_PRT  = 4'h4,
		CDR_FN_OUT_PUN  = 4'h5,
		CDR_FN_OUT_BOTH = 4'h6,
		CDR_FN_OUT_TTY  = 4'h7,
		CDR_FN_OUT_STOP = 4'h8
	} cdr_func_e;

	// active on-line input function
	typedef enum logic [1:0] {
		CDR_IN_NONE = 2'h0,
		CDR_IN_KBD  = 2'h1,
		CDR_IN_RDR  = 2'h2
	} cdr_in_e;

	// frame sequencer states
	typedef enum logic [2:0] {
		CDR_ST_IDLE   = 3'h0,
		CDR_ST_ISSUE1 = 3'h1,
		CDR_ST_WAIT1  = 3'h2,
		CDR_ST_ISSUE2 = 3'h3,
		CDR_ST_WAIT2  = 3'h4,
		CDR_ST_ADV    = 3'h5,
		CDR_ST_SENSE  = 3'h6
	} cdr_state_e;

endpackage : cdr_pkg

/* design/cdr_route_ctrl.sv */
// console data routing control: mode, function translation and frame sequencing
//
// What this block does
// [RULE1] on-line: one input and one output function at once; printer plus punch allowed
// [RULE2] computer directs on-line work, the panel directs off-line work
// [RULE3] teletype output only while printer, keyboard, punch and reader are off-line
// [RULE4] on-line key codes go to both the computer and the printer
// [RULE5] off-line key codes go to printer and punch, never to the computer
// [RULE6] printer fed by computer and keyboard on-line, keyboard or reader off-line
// [RULE7] reader frames go to computer on-line, to punch and/or printer off-line
// [RULE8] punch fed by computer on-line, by reader or keyboard off-line
// [RULE9] five off-line routes: k-p, k-p+punch, r-punch, r-p, r-p+punch
// [RULE10] each key press moves one seven-bit code to every selected destination
// [RULE11] keyboard to printer and punch sends each code to both
// [RULE12] duplication handles 5 to 8 level tape and starts on reader enable
// [RULE13] per frame: read, pass to punch, punch, advance, repeat
// [RULE14] duplication stops after last punch once no feed hole is seen
// [RULE15] reader to printer: read, send, print, advance, repeat
// [RULE16] reader to printer stops after last print once no feed hole is seen
// [RULE17] reader to punch and printer: punch first, then print, then advance
// [RULE18] captured words are held until delivered to their destination
// [RULE19] interrupt signals pass both ways between console and computer
// [RULE20] function words decode into subcommands, sequenced by timing steps
// [RULE21] reader advances only after every selected destination reports done
// [RULE22] mode is sampled only between frames
`timescale 1ns/1ps
`default_nettype none
module cdr_route_ctrl #(
	parameter int FRAME_W = cdr_pkg::FRAME_W
) (
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 sys_rst_i,
	// panel
	input  wire logic                 online_sel_i,
	input  wire logic [2:0]           route_sel_i,
	input  wire logic                 reader_enable_i,
	input  wire logic [1:0]           level_sel_i,
	input  wire logic                 periph_offline_i,
	// computer function and output words
	input  wire logic                 host_func_valid_i,
	input  wire logic [3:0]           host_func_i,
	output logic                      host_func_ready_o,
	input  wire logic                 host_data_valid_i,
	input  wire logic [FRAME_W-1:0]   host_data_i,
	output logic                      host_data_ready_o,
	// computer input words and interrupts
	output logic                      host_in_valid_o,
	output logic [FRAME_W-1:0]        host_in_data_o,
	input  wire logic                 host_in_ack_i,
	input  wire logic                 host_intr_i,
	output logic                      console_intr_o,
	// keyboard
	input  wire logic                 kbd_valid_i,
	input  wire logic [6:0]           kbd_data_i,
	output logic                      kbd_ready_o,
	// tape reader
	input  wire logic                 rdr_ready_i,
	input  wire logic                 rdr_feed_hole_i,
	input  wire logic [FRAME_W-1:0]   rdr_data_i,
	output logic                      rdr_advance_o,
	// printer
	output logic                      prt_strobe_o,
	output logic [6:0]                prt_data_o,
	input  wire logic                 prt_done_i,
	// punch
	output logic                      pun_strobe_o,
	output logic [FRAME_W-1:0]        pun_data_o,
	input  wire logic                 pun_done_i,
	// teletype output port
	output logic                      teletype_output_port_strobe_o,
	output logic [6:0]                teletype_output_port_data_o,
	input  wire logic                 teletype_output_port_done_i,
	// status
	output logic                      online_o,
	output logic                      busy_o
);

	// the masks and tape levels assume a full eight-level frame
	if (FRAME_W != 8) begin : g_bad_width
		$error("cdr_route_ctrl: FRAME_W must be 8");
	end

	cdr_pkg::cdr_state_e st;
	cdr_pkg::cdr_in_e    in_fn;
	logic                online;
	logic [3:0]          out_mask;
	logic [3:0]          mask1;
	logic [3:0]          mask2;
	logic [3:0]          pend;
	logic [3:0]          cur_mask;
	logic [3:0]          done_v;
	logic [7:0]          word;
	logic [7:0]          lvl_mask;
	logic                from_rdr;
	logic                func_fire;
	logic                data_fire;
	logic                kbd_src;
	logic                kbd_fire;
	logic                rdr_src;
	logic                rdr_fire;
	logic                rdr_end;
	logic                out_ok;
	logic                issue;

	// reader frame destinations, {second step, first step}
	function automatic logic [7:0] rdr_masks(input logic on, input logic [2:0] rt);
		logic [7:0] m;
		m = {cdr_pkg::DEST_NONE, cdr_pkg::DEST_NONE};
		if (on)
			m = {cdr_pkg::DEST_NONE, cdr_pkg::DEST_HOST}; // RULE7
		else
			case (rt)
				cdr_pkg::CDR_RT_RDR_PUN: m = {cdr_pkg::DEST_NONE, cdr_pkg::DEST_PUN}; // RULE13
				cdr_pkg::CDR_RT_RDR_PRT: m = {cdr_pkg::DEST_NONE, cdr_pkg::DEST_PRT}; // RULE15
				cdr_pkg::CDR_RT_RDR_PRT_PUN: m = {cdr_pkg::DEST_PRT, cdr_pkg::DEST_PUN}; // RULE17
				default: m = {cdr_pkg::DEST_NONE, cdr_pkg::DEST_NONE};
			endcase
		return m;
	endfunction : rdr_masks

	// function translator: output function word to destination mask
	function automatic logic [3:0] fn_out(input logic [3:0] fn);
		logic [3:0] m;
		case (fn)
			cdr_pkg::CDR_FN_OUT_PRT:  m = cdr_pkg::DEST_PRT;
			cdr_pkg::CDR_FN_OUT_PUN:  m = cdr_pkg::DEST_PUN;
			cdr_pkg::CDR_FN_OUT_BOTH: m = cdr_pkg::DEST_PRT | cdr_pkg::DEST_PUN;
			cdr_pkg::CDR_FN_OUT_TTY:  m = cdr_pkg::DEST_TTY;
			default:                  m = cdr_pkg::DEST_NONE;
		endcase
		return m;
	endfunction : fn_out

	// source qualification; only the idle step takes new work
	always_comb
	begin
		kbd_src = online ? (in_fn == cdr_pkg::CDR_IN_KBD)
			: (route_sel_i == cdr_pkg::CDR_RT_KBD_PRT || route_sel_i == cdr_pkg::CDR_RT_KBD_PRT_PUN);
		rdr_src = online ? (in_fn == cdr_pkg::CDR_IN_RDR)
			: (reader_enable_i && (route_sel_i == cdr_pkg::CDR_RT_RDR_PUN
			|| route_sel_i == cdr_pkg::CDR_RT_RDR_PRT
			|| route_sel_i == cdr_pkg::CDR_RT_RDR_PRT_PUN)); // RULE12
		// teletype only with peripherals off-line, the others only with them on-line
		out_ok = out_mask[cdr_pkg::D_TTY] ? periph_offline_i : !periph_offline_i; // RULE3
		host_func_ready_o = online && (st == cdr_pkg::CDR_ST_IDLE); // RULE2
		host_data_ready_o = online && (st == cdr_pkg::CDR_ST_IDLE) && (out_mask != cdr_pkg::DEST_NONE)
			&& out_ok; // RULE3
		kbd_ready_o = (st == cdr_pkg::CDR_ST_IDLE) && kbd_src && !host_data_valid_i;
		func_fire = host_func_valid_i && host_func_ready_o;
		data_fire = host_data_valid_i && host_data_ready_o;
		kbd_fire  = kbd_valid_i && kbd_ready_o;
		rdr_fire  = (st == cdr_pkg::CDR_ST_IDLE) && rdr_src && !data_fire && !kbd_fire
			&& rdr_ready_i && rdr_feed_hole_i;
		rdr_end   = (st == cdr_pkg::CDR_ST_SENSE) && rdr_ready_i && !rdr_feed_hole_i; // RULE14 RULE16
		lvl_mask  = cdr_pkg::FRAME_ALL >> (cdr_pkg::LEVEL_TOP - level_sel_i); // RULE12
		issue     = (st == cdr_pkg::CDR_ST_ISSUE1) || (st == cdr_pkg::CDR_ST_ISSUE2);
		cur_mask  = (st == cdr_pkg::CDR_ST_ISSUE1) ? mask1 : mask2;
		done_v    = {teletype_output_port_done_i, host_in_ack_i, prt_done_i, pun_done_i};
	end

	// mode latch changes only in idle so a frame never straddles a mode change
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			online <= 1'b0;
		else if (st == cdr_pkg::CDR_ST_IDLE)
			online <= online_sel_i; // RULE22 RULE2
	end

	// one input and one output function register; a computer interrupt clears both
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || !online || host_intr_i)
		begin
			in_fn    <= cdr_pkg::CDR_IN_NONE; // RULE19
			out_mask <= cdr_pkg::DEST_NONE;
		end
		else if (func_fire)
		begin
			case (host_func_i) // RULE20 RULE1
				cdr_pkg::CDR_FN_IN_KBD:   in_fn <= cdr_pkg::CDR_IN_KBD;
				cdr_pkg::CDR_FN_IN_RDR:   in_fn <= cdr_pkg::CDR_IN_RDR;
				cdr_pkg::CDR_FN_IN_STOP:  in_fn <= cdr_pkg::CDR_IN_NONE;
				cdr_pkg::CDR_FN_OUT_STOP: out_mask <= cdr_pkg::DEST_NONE;
				default:
				begin
					if (fn_out(host_func_i) != cdr_pkg::DEST_NONE)
						out_mask <= fn_out(host_func_i);
				end
			endcase
		end
		else if (rdr_end)
			in_fn <= cdr_pkg::CDR_IN_NONE;
	end

	// frame sequencer: capture, one or two delivery steps, then tape advance for reader frames
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			st       <= cdr_pkg::CDR_ST_IDLE;
			word     <= 8'h00;
			mask1    <= cdr_pkg::DEST_NONE;
			mask2    <= cdr_pkg::DEST_NONE;
			from_rdr <= 1'b0;
		end
		else
		begin
			case (st)
				cdr_pkg::CDR_ST_IDLE:
				begin
					if (data_fire)
					begin
						word     <= host_data_i; // RULE18
						mask1    <= out_mask; // RULE1 RULE6 RULE8
						mask2    <= cdr_pkg::DEST_NONE;
						from_rdr <= 1'b0;
						st       <= cdr_pkg::CDR_ST_ISSUE1;
					end
					else if (kbd_fire)
					begin
						word     <= {1'b0, kbd_data_i}; // RULE10
						// on-line keys echo to the printer; off-line never reach the host
						if (online)
							mask1 <= cdr_pkg::DEST_HOST | cdr_pkg::DEST_PRT; // RULE4
						else if (route_sel_i == cdr_pkg::CDR_RT_KBD_PRT_PUN)
							mask1 <= cdr_pkg::DEST_PRT | cdr_pkg::DEST_PUN; // RULE11 RULE5
						else
							mask1 <= cdr_pkg::DEST_PRT; // RULE9
						mask2    <= cdr_pkg::DEST_NONE;
						from_rdr <= 1'b0;
						st       <= cdr_pkg::CDR_ST_ISSUE1;
					end
					else if (rdr_fire)
					begin
						word             <= rdr_data_i & lvl_mask;
						{mask2, mask1}   <= rdr_masks(online, route_sel_i); // RULE9
						from_rdr         <= 1'b1;
						st               <= cdr_pkg::CDR_ST_ISSUE1;
					end
				end
				cdr_pkg::CDR_ST_ISSUE1: st <= cdr_pkg::CDR_ST_WAIT1;
				cdr_pkg::CDR_ST_WAIT1:
				begin
					if (pend == cdr_pkg::DEST_NONE)
					begin
						if (mask2 != cdr_pkg::DEST_NONE)
							st <= cdr_pkg::CDR_ST_ISSUE2; // RULE17
						else if (from_rdr)
							st <= cdr_pkg::CDR_ST_ADV; // RULE21
						else
							st <= cdr_pkg::CDR_ST_IDLE;
					end
				end
				cdr_pkg::CDR_ST_ISSUE2: st <= cdr_pkg::CDR_ST_WAIT2;
				cdr_pkg::CDR_ST_WAIT2:
				begin
					if (pend == cdr_pkg::DEST_NONE)
						st <= cdr_pkg::CDR_ST_ADV; // RULE21
				end
				cdr_pkg::CDR_ST_ADV: st <= cdr_pkg::CDR_ST_SENSE; // RULE13
				cdr_pkg::CDR_ST_SENSE:
				begin
					// a fresh frame restarts delivery; a missing feed hole ends the run
					if (rdr_ready_i && rdr_feed_hole_i)
					begin
						word           <= rdr_data_i & lvl_mask;
						{mask2, mask1} <= rdr_masks(online, route_sel_i);
						st             <= cdr_pkg::CDR_ST_ISSUE1;
					end
					else if (rdr_end)
						st <= cdr_pkg::CDR_ST_IDLE; // RULE14 RULE16
				end
				default: st <= cdr_pkg::CDR_ST_IDLE;
			endcase
		end
	end

	// outstanding destinations: set on issue, cleared by each done
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			pend <= cdr_pkg::DEST_NONE;
		else
			pend <= (pend & ~done_v) | (issue ? cur_mask : cdr_pkg::DEST_NONE); // RULE18
	end

	// dispatch strobes and held data; data stays until the next issue
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			prt_strobe_o                  <= 1'b0;
			pun_strobe_o                  <= 1'b0;
			teletype_output_port_strobe_o <= 1'b0;
			prt_data_o                    <= 7'h00;
			pun_data_o                    <= 8'h00;
			teletype_output_port_data_o   <= 7'h00;
			host_in_data_o                <= 8'h00;
		end
		else
		begin
			prt_strobe_o                  <= issue && cur_mask[cdr_pkg::D_PRT];
			pun_strobe_o                  <= issue && cur_mask[cdr_pkg::D_PUN];
			teletype_output_port_strobe_o <= issue && cur_mask[cdr_pkg::D_TTY]; // RULE3
			if (issue)
			begin
				prt_data_o                  <= word[6:0];
				pun_data_o                  <= word;
				teletype_output_port_data_o <= word[6:0];
				host_in_data_o              <= word;
			end
		end
	end

	// console-to-computer interrupt on each input word and at an on-line end of tape
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			console_intr_o <= 1'b0;
		else
			console_intr_o <= (issue && cur_mask[cdr_pkg::D_HOST]) || (rdr_end && online); // RULE19
	end

	assign host_in_valid_o = pend[cdr_pkg::D_HOST];
	assign rdr_advance_o   = (st == cdr_pkg::CDR_ST_ADV); // RULE13
	assign online_o        = online;
	assign busy_o          = (st != cdr_pkg::CDR_ST_IDLE);

	sequence s_key_in;
		kbd_fire && !online;
	endsequence
	sequence s_print_out;
		(st == cdr_pkg::CDR_ST_ISSUE1) ##1 prt_strobe_o;
	endsequence

	property p_key_prints;
		@(posedge clk_i) disable iff (sys_rst_i) s_key_in |=> s_print_out;
	endproperty
	a_key_prints: assert property (p_key_prints) else $error("key code not printed"); // RULE10
	property p_no_host_offline;
		@(posedge clk_i) disable iff (sys_rst_i) !online |-> !host_in_valid_o && !console_intr_o;
	endproperty
	a_no_host_offline: assert property (p_no_host_offline) else $error("host fed off-line"); // RULE5
	property p_online_key;
		@(posedge clk_i) disable iff (sys_rst_i) kbd_fire && online |-> ##2 host_in_valid_o;
	endproperty
	a_online_key: assert property (p_online_key) else $error("key not sent to host"); // RULE4
	property p_adv_done;
		@(posedge clk_i) disable iff (sys_rst_i) rdr_advance_o |-> pend == cdr_pkg::DEST_NONE;
	endproperty
	a_adv_done: assert property (p_adv_done) else $error("advance before done"); // RULE21
	property p_adv_once;
		@(posedge clk_i) disable iff (sys_rst_i) rdr_advance_o |=> !rdr_advance_o ##1 1'b1;
	endproperty
	a_adv_once: assert property (p_adv_once) else $error("advance longer than one cycle"); // RULE13
	property p_mode_hold;
		@(posedge clk_i) disable iff (sys_rst_i) busy_o |=> $stable(online);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed mid frame"); // RULE22
	property p_hold_word;
		@(posedge clk_i) disable iff (sys_rst_i)
			(st == cdr_pkg::CDR_ST_WAIT1) && pend != cdr_pkg::DEST_NONE |=> $stable(word);
	endproperty
	a_hold_word: assert property (p_hold_word) else $error("word lost before delivery"); // RULE18
	property p_tape_end;
		@(posedge clk_i) disable iff (sys_rst_i) rdr_end |=> !busy_o;
	endproperty
	a_tape_end: assert property (p_tape_end) else $error("run did not stop at tape end"); // RULE14
	property p_punch_first;
		@(posedge clk_i) disable iff (sys_rst_i)
			(st == cdr_pkg::CDR_ST_ISSUE2) |-> $past(pend) == cdr_pkg::DEST_NONE ##1 !pun_strobe_o;
	endproperty
	a_punch_first: assert property (p_punch_first) else $error("print before punch done"); // RULE17
	property p_tty_gate;
		@(posedge clk_i) disable iff (sys_rst_i) teletype_output_port_strobe_o |-> online;
	endproperty
	a_tty_gate: assert property (p_tty_gate) else $error("teletype used off-line"); // RULE3

endmodule : cdr_route_ctrl
`default_nettype wire
